// >>> hw/dtc_cycle_config.v
/*
 * Pacing configuration for the dynamic fan-start-temperature loop:
 * interval codes for the local and remote channels, the maximum PWM duty
 * limits and the write-once limit lock, plus pacing timers for the local and remote B channels.
 * Assumes a serial management front end that delivers decoded single-cycle
 * write and read strobes synchronous to clk.
 */
// Contract
// - Local code n spaces decreases 8*2^n cycles apart, increases twice that.
// - Remote B code: bits 7:6 here, third bit in dynamic control register 1.
// - Remote B code n: decreases every 8*2^n cycles, increases double.
// - With limit lock set, the interval register ignores all writes.
// - Every maximum PWM duty limit resets to full scale.
// - Local code in bits 5:3, remote A code in bits 2:0, read/write.
// - Three maximum duty limits sit at consecutive addresses, read/write.
// - Lock bit is write-once; lockable registers stay locked until reset.
`default_nettype none
`include "dtc_cycle_map.vh"

module dtc_cycle_config #(
    parameter [31:0] MON_TICK_CLKS = `DTC_MON_TICK_CLKS // Clocks per monitoring cycle.
) (
    input  wire       clk,              // System clock, 250 MHz.
    input  wire       rst_n,            // Power-on reset, asynchronous, active low.
    input  wire       wrEn,             // Pulse: register write.
    input  wire [7:0] wrAddr,           // Write address.
    input  wire [7:0] wrData,           // Write data.
    input  wire       rdEn,             // Pulse: register read.
    input  wire [7:0] rdAddr,           // Read address.
    output reg  [7:0] rdData_q,         // Read data, one cycle after rdEn.
    output reg        rdValid_q,        // Pulse: rdData_q is valid.
    output reg        wrRefused_q,      // Pulse: a write was dropped by the lock.
    input  wire       locAdjDone,       // Pulse: local threshold was adjusted.
    input  wire       rmtBAdjDone,      // Pulse: remote B threshold was adjusted.
    output wire       locDecOk,         // Local decrease permitted.
    output wire       locIncOk,         // Local increase permitted.
    output wire       rmtBDecOk,        // Remote B decrease permitted.
    output wire       rmtBIncOk,        // Remote B increase permitted.
    output wire       monTick,          // Pulse: one monitoring cycle.
    output wire [2:0] localAdjustInterval,   // Local interval code.
    output wire [2:0] remoteAAdjustInterval, // Remote A interval code.
    output wire [2:0] remoteBAdjustInterval, // Remote B interval code.
    output wire [7:0] pwmMax1,          // Maximum duty, PWM output 1.
    output wire [7:0] pwmMax2,          // Maximum duty, PWM output 2.
    output wire [7:0] pwmMax3,          // Maximum duty, PWM output 3.
    output wire       limitLock         // Limit lock state.
);

    localparam ST_RUN    = 2'b01;
    localparam ST_LOCKED = 2'b10;

    function isPwmAddr;
        input [7:0] a;
        begin
            isPwmAddr = (a >= `DTC_ADDR_PWM_MAX_FIRST) && (a <= `DTC_ADDR_PWM_MAX_LAST);
        end
    endfunction

    reg  [7:0] interval_q;
    reg  [7:0] dynCtrl1_q;
    reg  [7:0] config1_q;
    wire [23:0] pwmFlat;
    reg  [1:0] lockState_q;
    reg  [1:0] lockState_d;
    reg  [31:0] tickCnt_q;
    reg        tick_q;
    wire       locked;
    wire       wrLockable;

    assign locked = (lockState_q == ST_LOCKED);

    // Only reset leaves the locked state, so a later write of zero cannot unlock.
    always @* begin
        case (lockState_q)
            ST_RUN: begin
                if (wrEn && wrAddr == `DTC_ADDR_CONFIG1 && wrData[`DTC_LOCK_BIT]) begin
                    lockState_d = ST_LOCKED;
                end else begin
                    lockState_d = ST_RUN;
                end
            end
            ST_LOCKED: begin
                lockState_d = ST_LOCKED;
            end
            default: begin
                lockState_d = ST_LOCKED;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockState_q <= ST_RUN;
        end else begin
            lockState_q <= lockState_d;
        end
    end

    // Only the registers this bank owns are lockable here; the lock bit itself
    // is also lockable, so once set it can never be written back to zero.
    assign wrLockable = wrEn &&
                        (wrAddr == `DTC_ADDR_INTERVAL || wrAddr == `DTC_ADDR_DYN_CTRL1 ||
                         wrAddr == `DTC_ADDR_CONFIG1 || isPwmAddr(wrAddr));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interval_q  <= `DTC_RST_INTERVAL;
            dynCtrl1_q  <= `DTC_RST_DYN_CTRL1;
            config1_q   <= `DTC_RST_CONFIG1;
            wrRefused_q <= 1'b0;
        end else begin
            wrRefused_q <= wrLockable && locked;
            if (wrEn && !locked) begin
                if (wrAddr == `DTC_ADDR_INTERVAL) begin
                    interval_q <= wrData;
                end
                if (wrAddr == `DTC_ADDR_DYN_CTRL1) begin
                    dynCtrl1_q <= wrData;
                end
                if (wrAddr == `DTC_ADDR_CONFIG1) begin
                    config1_q <= wrData;
                end
            end
        end
    end

    // Each limit lives in its own generate block, so every register has exactly
    // one driving process; the flat vector gathers them for the read mux.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gPwm
            reg [7:0] limit_q;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    limit_q <= `DTC_RST_PWM_MAX;
                end else if (wrEn && !locked &&
                             wrAddr == `DTC_ADDR_PWM_MAX_FIRST + g) begin
                    limit_q <= wrData;
                end
            end
            assign pwmFlat[8*g +: 8] = limit_q;
        end
    endgenerate

    // A read in the same cycle as a write to that address returns the old value.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= rdEn;
            if (rdEn) begin
                if (rdAddr == `DTC_ADDR_INTERVAL) begin
                    rdData_q <= interval_q;
                end else if (rdAddr == `DTC_ADDR_DYN_CTRL1) begin
                    rdData_q <= dynCtrl1_q;
                end else if (rdAddr == `DTC_ADDR_CONFIG1) begin
                    rdData_q <= {config1_q[7:2], locked, config1_q[0]};
                end else if (isPwmAddr(rdAddr)) begin
                    rdData_q <= pwmFlat[{rdAddr[1:0], 3'h0} +: 8];
                end else begin
                    rdData_q <= 8'h00;
                end
            end
        end
    end

    // Monitoring-cycle pacing from the system clock. The tick runs freely, so
    // an adjustment may fall anywhere inside a monitoring cycle and the first
    // interval after it can be up to one tick short of its nominal length.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= 32'h00000000;
            tick_q    <= 1'b0;
        end else begin
            if (tickCnt_q >= MON_TICK_CLKS - 32'h00000001) begin
                tickCnt_q <= 32'h00000000;
                tick_q    <= 1'b1;
            end else begin
                tickCnt_q <= tickCnt_q + 32'h00000001;
                tick_q    <= 1'b0;
            end
        end
    end

    assign monTick = tick_q;

    assign localAdjustInterval   = interval_q[`DTC_LOC_MSB:`DTC_LOC_LSB];
    assign remoteAAdjustInterval = interval_q[`DTC_RA_MSB:`DTC_RA_LSB];
    assign remoteBAdjustInterval = {dynCtrl1_q[`DTC_RB_LO_BIT],
                                    interval_q[`DTC_RB_HI_MSB:`DTC_RB_HI_LSB]};
    assign pwmMax1   = pwmFlat[7:0];
    assign pwmMax2   = pwmFlat[15:8];
    assign pwmMax3   = pwmFlat[23:16];
    assign limitLock = locked;

    dtc_interval_timer uLocTimer (
        .clk     (clk),
        .rst_n   (rst_n),
        .monTick (tick_q),
        .code    (localAdjustInterval),
        .adjDone (locAdjDone),
        .decOk   (locDecOk),
        .incOk   (locIncOk)
    );

    dtc_interval_timer uRmtBTimer (
        .clk     (clk),
        .rst_n   (rst_n),
        .monTick (tick_q),
        .code    (remoteBAdjustInterval),
        .adjDone (rmtBAdjDone),
        .decOk   (rmtBDecOk),
        .incOk   (rmtBIncOk)
    );

endmodule // dtc_cycle_config

`default_nettype wire

// >>> hw/dtc_cycle_map.vh
/*
 * Register offsets, field positions, reset values and timing constants for
 * the dynamic fan-start-temperature pacing register bank.
 * Assumes it is included by bare name from the design files under hw/.
 */
`ifndef DTC_CYCLE_MAP_VH
`define DTC_CYCLE_MAP_VH

`define DTC_ADDR_DYN_CTRL1     8'h36
`define DTC_ADDR_INTERVAL      8'h37
`define DTC_ADDR_PWM_MAX_FIRST 8'h38
`define DTC_ADDR_PWM_MAX_LAST  8'h3a
`define DTC_ADDR_CONFIG1       8'h40

`define DTC_RB_HI_MSB          7
`define DTC_RB_HI_LSB          6
`define DTC_LOC_MSB            5
`define DTC_LOC_LSB            3
`define DTC_RA_MSB             2
`define DTC_RA_LSB             0
`define DTC_RB_LO_BIT          0
`define DTC_LOCK_BIT           1

`define DTC_RST_INTERVAL       8'h00
`define DTC_RST_DYN_CTRL1      8'h00
`define DTC_RST_PWM_MAX        8'hff
`define DTC_RST_CONFIG1        8'h01

`define DTC_BASE_DEC_CYCLES    12'h008
`define DTC_SAT_CYCLES         12'h800
`define DTC_MON_RATE_HZ        8
`define DTC_CLK_HZ             250000000
`define DTC_MON_TICK_CLKS      (`DTC_CLK_HZ / `DTC_MON_RATE_HZ)

`endif

// >>> hw/dtc_interval_timer.v
/*
 * One channel's pacing timer: counts monitoring cycles since the last
 * fan-start-temperature adjustment and reports when a decrease or an
 * increase may next be made.
 * Assumes monTick is a one-clock pulse per monitoring cycle.
 */
`default_nettype none
`include "dtc_cycle_map.vh"

module dtc_interval_timer (
    input  wire       clk,       // System clock.
    input  wire       rst_n,     // Asynchronous reset, active low.
    input  wire       monTick,   // One pulse per monitoring cycle.
    input  wire [2:0] code,      // Interval code of this channel.
    input  wire       adjDone,   // Pulse: an adjustment was just made.
    output wire       decOk,     // A decrease may be made now.
    output wire       incOk      // An increase may be made now.
);

    function [11:0] decCycles;
        input [2:0] c;
        begin
            decCycles = `DTC_BASE_DEC_CYCLES << c;
        end
    endfunction

    reg  [11:0] elapsed_q;
    wire [11:0] elapsed_d;
    wire [11:0] decLimit;
    wire [11:0] incLimit;

    // The count saturates at the longest interval so it never wraps back
    // into a window where adjustments would wrongly be refused.
    assign elapsed_d = adjDone ? 12'h000 :
                       (monTick && elapsed_q != `DTC_SAT_CYCLES) ?
                       elapsed_q + 12'h001 : elapsed_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_q <= 12'h000;
        end else begin
            elapsed_q <= elapsed_d;
        end
    end

    assign decLimit = decCycles(code);
    assign incLimit = {decLimit[10:0], 1'b0};
    assign decOk    = (elapsed_q >= decLimit);
    assign incOk    = (elapsed_q >= incLimit);

endmodule // dtc_interval_timer

`default_nettype wire

// >>> tb/dtc_cycle_config_properties.sv
/* Checker for the fan-start-temperature pacing register bank.
   Bound into dtc_cycle_config; sees only its ports and shares its tick parameter. */
`default_nettype none
module dtc_cycle_props #(
    parameter [31:0] MON_TICK_CLKS = 4 // Clocks per monitoring cycle.
) (
    input wire logic       clk,                   // System clock.
    input wire logic       rst_n,                 // Reset, active low.
    input wire logic       wrEn,                  // Write strobe.
    input wire logic [7:0] wrAddr,                // Write address.
    input wire logic [7:0] wrData,                // Write data.
    input wire logic       rdEn,                  // Read strobe.
    input wire logic [7:0] rdAddr,                // Read address.
    input wire logic [7:0] rdData_q,              // Read data.
    input wire logic       rdValid_q,             // Read data valid.
    input wire logic       wrRefused_q,           // Locked write dropped.
    input wire logic       locAdjDone,            // Local adjustment pulse.
    input wire logic       rmtBAdjDone,           // Remote B adjustment pulse.
    input wire logic       locDecOk,              // Local decrease permit.
    input wire logic       locIncOk,              // Local increase permit.
    input wire logic       rmtBDecOk,             // Remote B decrease permit.
    input wire logic       rmtBIncOk,             // Remote B increase permit.
    input wire logic       monTick,               // Monitoring cycle pulse.
    input wire logic [2:0] localAdjustInterval,   // Local interval code.
    input wire logic [2:0] remoteAAdjustInterval, // Remote A interval code.
    input wire logic [2:0] remoteBAdjustInterval, // Remote B interval code.
    input wire logic [7:0] pwmMax1,               // Duty limit 1.
    input wire logic [7:0] pwmMax2,               // Duty limit 2.
    input wire logic [7:0] pwmMax3,               // Duty limit 3.
    input wire logic       limitLock              // Lock state.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reference counters mirror the pacing rule so the permit outputs can be judged every cycle.
    logic [11:0] locCnt_q, rmtCnt_q;
    logic [31:0] gap_q;
    logic        seen_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locCnt_q <= 12'h000;
            rmtCnt_q <= 12'h000;
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            if (locAdjDone) locCnt_q <= 12'h000;
            else if (monTick && locCnt_q != 12'h800) locCnt_q <= locCnt_q + 12'h001;
            if (rmtBAdjDone) rmtCnt_q <= 12'h000;
            else if (monTick && rmtCnt_q != 12'h800) rmtCnt_q <= rmtCnt_q + 12'h001;
            gap_q <= monTick ? 32'h0 : gap_q + 32'h1;
            seen_q <= seen_q | monTick;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdPwm; rdEn && rdAddr == 8'h39 |=> rdValid_q && rdData_q == $past(pwmMax2); endproperty
    a_rdPwm: assert property (p_rdPwm) else $error("pwm limit read wrong");
    property p_pwmRst; $rose(rst_n) |-> {pwmMax1, pwmMax2, pwmMax3} == 24'hffffff; endproperty
    a_pwmRst: assert property (p_pwmRst) else $error("pwm limit reset wrong");
    property p_locWr;
        wrEn && wrAddr == 8'h37 && !limitLock |=> {localAdjustInterval, remoteAAdjustInterval,
            remoteBAdjustInterval[1:0]} == $past({wrData[5:3], wrData[2:0], wrData[7:6]});
    endproperty
    a_locWr: assert property (p_locWr) else $error("interval fields wrong");
    property p_rbHi; wrEn && wrAddr == 8'h36 && !limitLock |=>
        remoteBAdjustInterval[2] == $past(wrData[0]); endproperty
    a_rbHi: assert property (p_rbHi) else $error("remote code top bit wrong");
    property p_lockWr; limitLock && wrEn && wrAddr == 8'h37 |=>
        wrRefused_q && $stable(localAdjustInterval); endproperty
    a_lockWr: assert property (p_lockWr) else $error("locked write not refused");
    property p_lockKeep; limitLock |=> limitLock; endproperty
    a_lockKeep: assert property (p_lockKeep) else $error("lock cleared");
    property p_pwmLock; limitLock && wrEn |=> $stable({pwmMax1, pwmMax2, pwmMax3}); endproperty
    a_pwmLock: assert property (p_pwmLock) else $error("locked limit changed");
    property p_loc; locDecOk == (locCnt_q >= (12'h008 << localAdjustInterval)) &&
        locIncOk == (locCnt_q >= (12'h010 << localAdjustInterval)); endproperty
    a_loc: assert property (p_loc) else $error("local permit wrong");
    property p_rmt; rmtBDecOk == (rmtCnt_q >= (12'h008 << remoteBAdjustInterval)) &&
        rmtBIncOk == (rmtCnt_q >= (12'h010 << remoteBAdjustInterval)); endproperty
    a_rmt: assert property (p_rmt) else $error("remote permit wrong");
    property p_tick; monTick && seen_q |-> gap_q == MON_TICK_CLKS - 1; endproperty
    a_tick: assert property (p_tick) else $error("tick spacing wrong");
    c_refuse: cover property (wrRefused_q);
    c_locInc: cover property ($rose(locIncOk));
    c_rmtInc: cover property ($rose(rmtBIncOk));
endmodule // dtc_cycle_props
bind dtc_cycle_config dtc_cycle_props #(.MON_TICK_CLKS(MON_TICK_CLKS)) props_u (
    .clk(clk), .rst_n(rst_n), .wrEn(wrEn), .rdEn(rdEn), .rdValid_q(rdValid_q),
    .wrRefused_q(wrRefused_q), .monTick(monTick), .limitLock(limitLock), .wrAddr(wrAddr),
    .wrData(wrData), .rdAddr(rdAddr), .rdData_q(rdData_q), .pwmMax1(pwmMax1),
    .pwmMax2(pwmMax2), .pwmMax3(pwmMax3), .locAdjDone(locAdjDone), .rmtBAdjDone(rmtBAdjDone),
    .locDecOk(locDecOk), .locIncOk(locIncOk), .rmtBDecOk(rmtBDecOk), .rmtBIncOk(rmtBIncOk),
    .localAdjustInterval(localAdjustInterval), .remoteAAdjustInterval(remoteAAdjustInterval),
    .remoteBAdjustInterval(remoteBAdjustInterval));
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench for the pacing register bank.
   Drives the plain write/read strobes and adjustment pulses; tick shortened to 4 clocks. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst_n = 1'b0, wrEn = 1'b0, rdEn = 1'b0, lAdj = 1'b0, rAdj = 1'b0;
    logic [7:0] wrAddr = 8'h00, wrData = 8'h00, rdAddr = 8'h00, rdData, p1, p2, p3;
    logic       rdValid, wrRef, lDec, lInc, rDec, rInc, tick, lock;
    logic [2:0] lCode, aCode, bCode;
    int         errors = 0, comparisons = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    dtc_cycle_config #(.MON_TICK_CLKS(4)) dut_u (.clk(clk), .rst_n(rst_n), .wrEn(wrEn),
        .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr), .rdData_q(rdData),
        .rdValid_q(rdValid), .wrRefused_q(wrRef), .locAdjDone(lAdj), .rmtBAdjDone(rAdj),
        .locDecOk(lDec), .locIncOk(lInc), .rmtBDecOk(rDec), .rmtBIncOk(rInc), .monTick(tick),
        .localAdjustInterval(lCode), .remoteAAdjustInterval(aCode),
        .remoteBAdjustInterval(bCode), .pwmMax1(p1), .pwmMax2(p2), .pwmMax3(p3), .limitLock(lock));
    task automatic chk(input string what, input logic [11:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        wrEn <= 1'b1;
        wrAddr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        chk("rdValid", 12'h001, rdValid);
        chk("rdData", exp, rdData);
    endtask
    task automatic t_reset;
        @(posedge clk);
        #1;
        chk("pwmMax1", 12'h0ff, p1);
        chk("pwmMax2", 12'h0ff, p2);
        chk("pwmMax3", 12'h0ff, p3);
        rd(8'h38, 8'hff);
        rd(8'h39, 8'hff);
        rd(8'h3a, 8'hff);
        wr(8'h3a, 8'h5a);
        chk("pwmMax3", 12'h05a, p3);
        chk("refused", 12'h000, wrRef);
        $display("test reset done");
    endtask
    task automatic t_fields;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(8'h37, {c[1:0], c, ~c});
            wr(8'h36, {7'h00, c[2]});
            chk("local", c, lCode);
            chk("remoteA", {9'h000, ~c}, aCode);
            chk("remoteB", c, bCode);
            rd(8'h37, {c[1:0], c, ~c});
        end
        $display("test fields done");
    endtask
    // Both channels run the same code so one pass judges both timers.
    task automatic t_pace(input logic [2:0] c);
        int n, ld, li, rd2, ri;
        n = 0;
        ld = -1;
        li = -1;
        rd2 = -1;
        ri = -1;
        wr(8'h37, {c[1:0], c, 3'h0});
        wr(8'h36, {7'h00, c[2]});
        @(posedge clk);
        lAdj <= 1'b1;
        rAdj <= 1'b1;
        @(posedge clk);
        lAdj <= 1'b0;
        rAdj <= 1'b0;
        while (n < 2100 && (li < 0 || ri < 0)) begin
            @(negedge clk);
            if (lDec && ld < 0) ld = n;
            if (lInc && li < 0) li = n;
            if (rDec && rd2 < 0) rd2 = n;
            if (rInc && ri < 0) ri = n;
            if (tick) n++;
        end
        chk("locDec", 12'(8 << c), 12'(ld));
        chk("locInc", 12'(16 << c), 12'(li));
        chk("rmtDec", 12'(8 << c), 12'(rd2));
        chk("rmtInc", 12'(16 << c), 12'(ri));
        @(posedge clk);
        lAdj <= 1'b1;
        @(posedge clk);
        lAdj <= 1'b0;
        #1;
        chk("locRestart", 12'h000, lDec);
        chk("rmtHeld", 12'h001, rDec);
        $display("test pace done");
    endtask
    task automatic t_lock;
        wr(8'h37, 8'h50);
        wr(8'h40, 8'h02);
        chk("lock", 12'h001, lock);
        wr(8'h37, 8'hff);
        chk("refused", 12'h001, wrRef);
        chk("local", 12'h002, lCode);
        rd(8'h37, 8'h50);
        wr(8'h38, 8'h00);
        chk("pwmMax1", 12'h0ff, p1);
        wr(8'h40, 8'h00);
        chk("lock", 12'h001, lock);
        rd(8'h40, 8'h02);
        rd(8'h55, 8'h00);
        $display("test lock done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_pace(3'h0);
        t_pace(3'h2);
        t_pace(3'h7);
        t_lock();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
